// ==== dbw_map.svh ====
`ifndef DBW_MAP_SVH
`define DBW_MAP_SVH
// What this block does
// - A comparator can trigger only while control bit 0 is set.
// - Control bits 23:16 enable each of eight threads individually.
// - Breakpoint bit 1: zero breaks on PC equal, one on PC different.
// - Four breakpoint control registers at indices 0x40 to 0x43.
// - Data watchpoints hold first addresses at 0x50, second at 0x60.
// - Data watchpoint bit 1: zero needs A and B, one A or B.
// - Data watchpoint bit 2 lets matching loads trigger.
// - Four data watchpoint control registers at indices 0x70 to 0x73.
// - Resource watchpoints hold masks at 0x80 and values at 0x90.
// - Resource watchpoint bit 1: zero triggers on masked match, one on mismatch.
// - Four resource watchpoint control registers at indices 0x9C to 0x9F.
// - Enabled breakpoint raises debug interrupt; addresses at 0x30.
// - Cause code 3 breakpoint, 4 data watch, 5 resource watch.
// - Data hit captures address, resource hit captures id, at 0x16.

// =====================================================
// Register indices (byte address is four times index)
`define DBW_IDX_IB_ADDR 8'h30
`define DBW_IDX_IB_CTL 8'h40
`define DBW_IDX_DW_FIRST 8'h50
`define DBW_IDX_DW_SECOND 8'h60
`define DBW_IDX_DW_CTL 8'h70
`define DBW_IDX_RW_MASK 8'h80
`define DBW_IDX_RW_VALUE 8'h90
`define DBW_IDX_RW_CTL 8'h9C
`define DBW_IDX_INT_TYPE 8'h15
`define DBW_IDX_INT_DATA 8'h16
`define DBW_IDX_IRQ_STATUS 8'hA0
`define DBW_IDX_IRQ_CLEAR 8'hA1
`define DBW_IDX_IRQ_ENABLE 8'hA2

// =====================================================
// Field positions
`define DBW_CTL_EN 0
`define DBW_CTL_SEL 1
`define DBW_CTL_LOAD 2
`define DBW_CTL_THR_LSB 16
`define DBW_IB_CTL_WMASK 32'h00FF0003
`define DBW_DW_CTL_WMASK 32'h00FF0007
`define DBW_RW_CTL_WMASK 32'h00FF0003
`define DBW_TYPE_IDX_LSB 16
`define DBW_TYPE_THR_LSB 8
`define DBW_ST_IB 0
`define DBW_ST_DW 1
`define DBW_ST_RW 2

// =====================================================
// Reset values
`define DBW_RST_WORD 32'h00000000
`define DBW_RST_IRQ 3'h0
`endif

// ==== dbw_pkg.sv ====
package dbw_pkg;

	// =====================================================
	// Pipeline observation carriers
	typedef struct packed {
		logic valid;
		logic [2:0] thread;
		logic [31:0] pc;
	} dbw_exec_type;

	typedef struct packed {
		logic valid;
		logic load;
		logic [2:0] thread;
		logic [31:0] addr;
	} dbw_mem_type;

	typedef struct packed {
		logic valid;
		logic [2:0] thread;
		logic [31:0] id;
	} dbw_res_type;

	typedef enum logic [2:0] {
		DBW_CAUSE_NONE = 3'h0,
		DBW_CAUSE_IBREAK = 3'h3,
		DBW_CAUSE_DWATCH = 3'h4,
		DBW_CAUSE_RWATCH = 3'h5
	} dbw_cause_type;

endpackage : dbw_pkg

// ==== dbw_unit.sv ====
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "dbw_map.svh"

module dbw_unit
	import dbw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire dbw_exec_type exec_obs,
	input wire dbw_mem_type load_obs,
	input wire dbw_res_type res_obs,
	output logic irq
);

	// =====================================================
	// Helpers
	function automatic logic in_group(input logic [7:0] idx, input logic [7:0] base);
		in_group = (idx[7:2] == base[7:2]);
	endfunction : in_group

	function automatic logic thread_on(input logic [31:0] ctl, input logic [2:0] thr);
		thread_on = ctl[`DBW_CTL_EN] && ctl[`DBW_CTL_THR_LSB + int'(thr)];
	endfunction : thread_on

	function automatic logic [1:0] lowest(input logic [3:0] v);
		lowest = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
	endfunction : lowest

	// =====================================================
	// Register storage
	logic [31:0] ib_addr_q [4];
	logic [31:0] ib_ctl_q [4];
	logic [31:0] dw_first_q [4];
	logic [31:0] dw_second_q [4];
	logic [31:0] dw_ctl_q [4];
	logic [31:0] rw_mask_q [4];
	logic [31:0] rw_value_q [4];
	logic [31:0] rw_ctl_q [4];
	logic [2:0] cause_q;
	logic [1:0] cidx_q;
	logic [7:0] cthr_q;
	logic [31:0] cdata_q;
	logic [2:0] st_q;
	logic [2:0] en_q;

	// =====================================================
	// AHB-Lite slave
	logic acc;
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] wr_idx_q;
	logic [7:0] rd_idx_q;
	logic [31:0] rd_mux;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	assign acc = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
			rd_idx_q <= 8'h00;
		end else begin
			wr_pend_q <= acc && hwrite;
			rd_pend_q <= acc && !hwrite;
			if (acc) begin
				wr_idx_q <= haddr[9:2];
				rd_idx_q <= haddr[9:2];
			end
		end
	end

	// Reads take one wait state so that a read right behind a write sees the new value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hrdata_q <= `DBW_RST_WORD;
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
			if (acc && !hwrite) begin
				hreadyout_q <= 1'b0;
			end else if (rd_pend_q) begin
				hreadyout_q <= 1'b1;
				hrdata_q <= rd_mux;
			end
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	always_comb begin
		rd_mux = `DBW_RST_WORD;
		if (in_group(rd_idx_q, `DBW_IDX_IB_ADDR)) begin
			rd_mux = ib_addr_q[rd_idx_q[1:0]];
		end else if (in_group(rd_idx_q, `DBW_IDX_IB_CTL)) begin
			rd_mux = ib_ctl_q[rd_idx_q[1:0]];
		end else if (in_group(rd_idx_q, `DBW_IDX_DW_FIRST)) begin
			rd_mux = dw_first_q[rd_idx_q[1:0]];
		end else if (in_group(rd_idx_q, `DBW_IDX_DW_SECOND)) begin
			rd_mux = dw_second_q[rd_idx_q[1:0]];
		end else if (in_group(rd_idx_q, `DBW_IDX_DW_CTL)) begin
			rd_mux = dw_ctl_q[rd_idx_q[1:0]];
		end else if (in_group(rd_idx_q, `DBW_IDX_RW_MASK)) begin
			rd_mux = rw_mask_q[rd_idx_q[1:0]];
		end else if (in_group(rd_idx_q, `DBW_IDX_RW_VALUE)) begin
			rd_mux = rw_value_q[rd_idx_q[1:0]];
		end else if (in_group(rd_idx_q, `DBW_IDX_RW_CTL)) begin
			rd_mux = rw_ctl_q[rd_idx_q[1:0]];
		end else if (rd_idx_q == `DBW_IDX_INT_TYPE) begin
			rd_mux[2:0] = cause_q;
			rd_mux[`DBW_TYPE_THR_LSB +: 8] = cthr_q;
			rd_mux[`DBW_TYPE_IDX_LSB +: 2] = cidx_q;
		end else if (rd_idx_q == `DBW_IDX_INT_DATA) begin
			rd_mux = cdata_q;
		end else if (rd_idx_q == `DBW_IDX_IRQ_STATUS) begin
			rd_mux[2:0] = st_q;
		end else if (rd_idx_q == `DBW_IDX_IRQ_ENABLE) begin
			rd_mux[2:0] = en_q;
		end
	end

	// =====================================================
	// Comparator register writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				ib_addr_q[i] <= `DBW_RST_WORD;
				ib_ctl_q[i] <= `DBW_RST_WORD;
				dw_first_q[i] <= `DBW_RST_WORD;
				dw_second_q[i] <= `DBW_RST_WORD;
				dw_ctl_q[i] <= `DBW_RST_WORD;
				rw_mask_q[i] <= `DBW_RST_WORD;
				rw_value_q[i] <= `DBW_RST_WORD;
				rw_ctl_q[i] <= `DBW_RST_WORD;
			end
		end else if (wr_pend_q) begin
			if (in_group(wr_idx_q, `DBW_IDX_IB_ADDR)) begin
				ib_addr_q[wr_idx_q[1:0]] <= hwdata;
			end
			if (in_group(wr_idx_q, `DBW_IDX_IB_CTL)) begin
				ib_ctl_q[wr_idx_q[1:0]] <= hwdata & `DBW_IB_CTL_WMASK;
			end
			if (in_group(wr_idx_q, `DBW_IDX_DW_FIRST)) begin
				dw_first_q[wr_idx_q[1:0]] <= hwdata;
			end
			if (in_group(wr_idx_q, `DBW_IDX_DW_SECOND)) begin
				dw_second_q[wr_idx_q[1:0]] <= hwdata;
			end
			if (in_group(wr_idx_q, `DBW_IDX_DW_CTL)) begin
				dw_ctl_q[wr_idx_q[1:0]] <= hwdata & `DBW_DW_CTL_WMASK;
			end
			if (in_group(wr_idx_q, `DBW_IDX_RW_MASK)) begin
				rw_mask_q[wr_idx_q[1:0]] <= hwdata;
			end
			if (in_group(wr_idx_q, `DBW_IDX_RW_VALUE)) begin
				rw_value_q[wr_idx_q[1:0]] <= hwdata;
			end
			if (in_group(wr_idx_q, `DBW_IDX_RW_CTL)) begin
				rw_ctl_q[wr_idx_q[1:0]] <= hwdata & `DBW_RW_CTL_WMASK;
			end
		end
	end

	// =====================================================
	// Comparators
	logic [3:0] ib_hit;
	logic [3:0] dw_hit;
	logic [3:0] rw_hit;

	always_comb begin
		logic ca;
		logic cb;
		logic cond;
		ca = 1'b0;
		cb = 1'b0;
		cond = 1'b0;
		for (int i = 0; i < 4; i++) begin
			// Equality flipped by the sense bit
			cond = (exec_obs.pc == ib_addr_q[i]) ^ ib_ctl_q[i][`DBW_CTL_SEL];
			ib_hit[i] = exec_obs.valid && thread_on(ib_ctl_q[i], exec_obs.thread) && cond;
			ca = load_obs.addr >= dw_first_q[i];
			cb = load_obs.addr <= dw_second_q[i];
			cond = dw_ctl_q[i][`DBW_CTL_SEL] ? (ca || cb) : (ca && cb);
			// Stores never trigger: a hit needs load_obs.load set as well as control bit 2
			dw_hit[i] = load_obs.valid && load_obs.load && dw_ctl_q[i][`DBW_CTL_LOAD]
				&& thread_on(dw_ctl_q[i], load_obs.thread) && cond;
			ca = (res_obs.id & rw_mask_q[i]) == rw_value_q[i];
			cond = rw_ctl_q[i][`DBW_CTL_SEL] ? !ca : ca;
			rw_hit[i] = res_obs.valid && thread_on(rw_ctl_q[i], res_obs.thread) && cond;
		end
	end

	// =====================================================
	// Cause capture; a hit in the same cycle as a software write wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_q <= DBW_CAUSE_NONE;
			cidx_q <= 2'h0;
			cthr_q <= 8'h00;
			cdata_q <= `DBW_RST_WORD;
		end else if (|ib_hit) begin
			cause_q <= DBW_CAUSE_IBREAK;
			cidx_q <= lowest(ib_hit);
			cthr_q <= {5'h00, exec_obs.thread};
		end else if (|dw_hit) begin
			cause_q <= DBW_CAUSE_DWATCH;
			cidx_q <= lowest(dw_hit);
			cthr_q <= {5'h00, load_obs.thread};
			cdata_q <= load_obs.addr;
		end else if (|rw_hit) begin
			cause_q <= DBW_CAUSE_RWATCH;
			cidx_q <= lowest(rw_hit);
			cthr_q <= {5'h00, res_obs.thread};
			cdata_q <= res_obs.id;
		end else if (wr_pend_q && wr_idx_q == `DBW_IDX_INT_TYPE) begin
			cause_q <= hwdata[2:0];
			cidx_q <= hwdata[`DBW_TYPE_IDX_LSB +: 2];
			cthr_q <= hwdata[`DBW_TYPE_THR_LSB +: 8];
		end else if (wr_pend_q && wr_idx_q == `DBW_IDX_INT_DATA) begin
			cdata_q <= hwdata;
		end
	end

	// =====================================================
	// Interrupt status, enable and output
	logic [2:0] st_set;
	logic [2:0] st_clr;

	always_comb begin
		st_set = `DBW_RST_IRQ;
		st_set[`DBW_ST_IB] = |ib_hit;
		st_set[`DBW_ST_DW] = |dw_hit;
		st_set[`DBW_ST_RW] = |rw_hit;
		st_clr = (wr_pend_q && wr_idx_q == `DBW_IDX_IRQ_CLEAR) ? hwdata[2:0] : `DBW_RST_IRQ;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= `DBW_RST_IRQ;
		end else begin
			st_q <= (st_q & ~st_clr) | st_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= `DBW_RST_IRQ;
		end else if (wr_pend_q && wr_idx_q == `DBW_IDX_IRQ_ENABLE) begin
			en_q <= hwdata[2:0];
		end
	end

	logic irq_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(st_q & en_q);
		end
	end

	assign irq = irq_q;

endmodule : dbw_unit

// ==== dbw_sva.sv ====
`timescale 1ns/1ps
module dbw_sva
	import dbw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire dbw_exec_type exec_obs,
	input wire dbw_mem_type load_obs,
	input wire dbw_res_type res_obs,
	input wire logic irq
);
	// ========
	// Bus and interrupt timing
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic rd_t;
	logic wr_t;
	logic obs_t;
	assign rd_t = hsel & hready & htrans[1] & ~hwrite;
	assign wr_t = hsel & hready & htrans[1] & hwrite;
	assign obs_t = exec_obs.valid | load_obs.valid | res_obs.valid;
	sequence s_rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_read_wait: assert property (rd_t |=> s_rd_wait) else $error("read not one wait state");
	a_write_fast: assert property (wr_t |=> hreadyout) else $error("write stalled");
	a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_t)) else $error("wait without read");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(!hreadyout)) else $error("read data moved");
	// Irq may only move after a hit or a register write, with the registered lag
	a_irq_rise: assert property ($rose(irq) |-> $past(obs_t, 2) || $past(wr_t, 3)) else $error("irq rose");
	a_irq_fall: assert property ($fell(irq) |-> $past(wr_t, 3)) else $error("irq fell unasked");
	a_reset_quiet: assert property (disable iff (1'b0) !hresetn |-> hreadyout && !irq && !hresp)
		else $error("outputs busy in reset");
endmodule : dbw_sva
bind dbw_unit dbw_sva i_dbw_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.exec_obs(exec_obs), .load_obs(load_obs), .res_obs(res_obs), .irq(irq));

// ==== dbw_pipe_model.sv ====
`timescale 1ns/1ps
module dbw_pipe_model
	import dbw_pkg::*;
(
	input wire logic hclk,
	output dbw_exec_type exec_obs,
	output dbw_mem_type load_obs,
	output dbw_res_type res_obs
);
	initial begin
		exec_obs = '0;
		load_obs = '0;
		res_obs = '0;
	end
	// ========
	// One observation cycle; idle payload is inverted so stale fields never look current
	task automatic fire(input dbw_exec_type e, input dbw_mem_type m, input dbw_res_type r);
		@(posedge hclk);
		exec_obs <= e;
		load_obs <= m;
		res_obs <= r;
		@(posedge hclk);
		exec_obs <= {1'b0, ~e[34:0]};
		load_obs <= {1'b0, ~m[35:0]};
		res_obs <= {1'b0, ~r[34:0]};
	endtask : fire
endmodule : dbw_pipe_model

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CMP(a, e) n_tests++; if ((a) !== (e)) begin error_cnt++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end
module testbench;
	import dbw_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	dbw_exec_type exec_obs;
	dbw_mem_type load_obs;
	dbw_res_type res_obs;
	int error_cnt = 0;
	int n_tests = 0;
	logic [2:0] en = 3'h0;
	logic [7:0] grp [8] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9C};
	logic [31:0] wm [8] = '{32'hFFFFFFFF, 32'h00FF0003, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00FF0007,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00FF0003};
	localparam dbw_exec_type nx = '0;
	localparam dbw_mem_type nm = '0;
	localparam dbw_res_type nr = '0;
	always #25 hclk = ~hclk;
	dbw_unit i_dbw_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .exec_obs(exec_obs), .load_obs(load_obs),
		.res_obs(res_obs), .irq(irq));
	dbw_pipe_model i_dbw_pipe_model (.hclk(hclk), .exec_obs(exec_obs), .load_obs(load_obs), .res_obs(res_obs));
	task automatic end_of_test;
		$display("compares %0d, wrong %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic wt;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				error_cnt++;
				end_of_test();
			end
			@(posedge hclk);
		end
	endtask : wt
	task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {22'h0, i, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
	endtask : acc
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, i, d, q);
	endtask : wr
	task automatic chk(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, i, 32'h0, q);
		`CMP(q, e)
	endtask : chk
	function automatic dbw_exec_type ex(logic [2:0] t, logic [31:0] pc);
		return {1'b1, t, pc};
	endfunction : ex
	function automatic dbw_mem_type ld(logic l, logic [2:0] t, logic [31:0] a);
		return {1'b1, l, t, a};
	endfunction : ld
	function automatic dbw_res_type rs(logic [2:0] t, logic [31:0] id);
		return {1'b1, t, id};
	endfunction : rs
	// Fires one cycle, checks status, irq and type, then clears the status
	task automatic hit(input dbw_exec_type e, input dbw_mem_type m, input dbw_res_type r,
		input logic [2:0] st, input logic [31:0] ty);
		i_dbw_pipe_model.fire(e, m, r);
		chk(8'hA0, {29'h0, st});
		`CMP(irq, |(st & en))
		if (st != 3'h0) begin
			chk(8'h15, ty);
		end
		wr(8'hA1, 32'h7);
		repeat (2) @(posedge hclk);
		`CMP(irq, 1'b0)
	endtask : hit
	initial begin
		int g;
		int k;
		int p;
		logic [31:0] d;
		// A real falling edge at time zero, so the flops hold reset values before the first sample
		hresetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (p = 0; p < 4; p++) begin
			for (g = 0; g < 8; g++) begin
				for (k = 0; k < 4; k++) begin
					d = 32'hFF00FFFC | (k << 16) | (g << 20) | k;
					case (p)
						0: chk(grp[g] + 8'(k), 32'h0);
						1: wr(grp[g] + 8'(k), d);
						2: chk(grp[g] + 8'(k), d & wm[g]);
						default: wr(grp[g] + 8'(k), 32'h0);
					endcase
				end
			end
		end
		wr(8'hB0, 32'hFFFFFFFF);
		chk(8'hB0, 32'h0);
		wr(8'hA0, 32'h7);
		chk(8'hA0, 32'h0);
		chk(8'h15, 32'h0);
		wr(8'h15, 32'h00030205);
		chk(8'h15, 32'h00030205);
		wr(8'h16, 32'h89ABCDEF);
		chk(8'h16, 32'h89ABCDEF);
		$display("test registers done");
		en = 3'h7;
		wr(8'hA2, 32'h7);
		wr(8'h32, 32'h1000);
		wr(8'h42, 32'h00010001);
		hit(ex(3'h0, 32'h1000), nm, nr, 3'h1, 32'h00020003);
		hit(ex(3'h1, 32'h1000), nm, nr, 3'h0, 32'h0);
		hit(ex(3'h0, 32'h1004), nm, nr, 3'h0, 32'h0);
		wr(8'h42, 32'h00010003);
		hit(ex(3'h0, 32'h1004), nm, nr, 3'h1, 32'h00020003);
		hit(ex(3'h0, 32'h1000), nm, nr, 3'h0, 32'h0);
		wr(8'h42, 32'h00010002);
		hit(ex(3'h0, 32'h1004), nm, nr, 3'h0, 32'h0);
		wr(8'h31, 32'h1000);
		wr(8'h41, 32'h00010001);
		wr(8'h42, 32'h00010001);
		hit(ex(3'h0, 32'h1000), nm, nr, 3'h1, 32'h00010003);
		$display("test breakpoints done");
		wr(8'h53, 32'h2000);
		wr(8'h63, 32'h2FFF);
		wr(8'h73, 32'h00020005);
		hit(nx, ld(1'b1, 3'h1, 32'h2000), nr, 3'h2, 32'h00030104);
		chk(8'h16, 32'h2000);
		hit(nx, ld(1'b0, 3'h1, 32'h2800), nr, 3'h0, 32'h0);
		hit(nx, ld(1'b1, 3'h1, 32'h3000), nr, 3'h0, 32'h0);
		hit(nx, ld(1'b1, 3'h1, 32'h1FFF), nr, 3'h0, 32'h0);
		wr(8'h73, 32'h00020007);
		hit(nx, ld(1'b1, 3'h1, 32'h3000), nr, 3'h2, 32'h00030104);
		wr(8'h73, 32'h00020003);
		hit(nx, ld(1'b1, 3'h1, 32'h2800), nr, 3'h0, 32'h0);
		$display("test data watch done");
		en = 3'h3;
		wr(8'hA2, 32'h3);
		wr(8'h80, 32'hFF);
		wr(8'h90, 32'h42);
		wr(8'h9C, 32'h00040001);
		hit(nx, nm, rs(3'h2, 32'h1242), 3'h4, 32'h00000205);
		chk(8'h16, 32'h1242);
		hit(nx, nm, rs(3'h2, 32'h1243), 3'h0, 32'h0);
		wr(8'h9C, 32'h00040003);
		hit(nx, nm, rs(3'h2, 32'h1243), 3'h4, 32'h00000205);
		hit(nx, nm, rs(3'h2, 32'h1242), 3'h0, 32'h0);
		en = 3'h7;
		wr(8'hA2, 32'h7);
		wr(8'h73, 32'h00020007);
		hit(ex(3'h0, 32'h1000), ld(1'b1, 3'h1, 32'h5), rs(3'h2, 32'h7), 3'h7, 32'h00010003);
		$display("test resource watch and priority done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		en = 3'h0;
		chk(8'h41, 32'h0);
		chk(8'h15, 32'h0);
		hit(ex(3'h0, 32'h1000), nm, nr, 3'h0, 32'h0);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule : testbench
